/* File: design/addr_map_decoder.sv */
// What this block does
// - Takes a 16-bit CPU address covering a 64K byte space.
// - Lowest 64 bytes form the register page with reserved holes.
// - Exactly 384 bytes of read/write RAM are mapped.
// - Four Kbytes of program memory are mapped.
// - Stack lives in RAM from 0100h to 017Fh, at most 128 bytes.
// - Topmost addresses hold reset and interrupt vectors for fetch.
// - First port data at 0000h, direction at 0001h, reset 00h.
// - Second port data at 0002h, direction at 0003h, reset 00h.
// - Addresses 0004h to 0007h are reserved.
// - Edge configuration at 0008h, miscellaneous control at 0009h resetting 00h.
// - Watchdog control at 000Dh resets 7Fh; 000Eh to 0024h reserved.
// - USB group starts with read-only packet id, DMA address next.
// - USB control is followed by the device address register.
// - Three endpoints have A and B registers; group ends at 0031h.
// - Timebase count at 0036h and control/status at 0037h, reset 00h.
// - Vector-holding program sector occupies F000h to FFFFh.
`include "addr_map_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module addr_map_decoder
  import addr_map_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // CPU access.
  input wire cpu_req_s req_i,
  output logic [7:0] rdata_o,
  output region_e region_o,
  // Peripheral status inputs.
  input wire logic [7:0] usb_packet_id_i,
  input wire logic stack_push_i,
  // Program memory loading.
  input wire logic prog_load_i,
  input wire logic [11:0] prog_load_addr_i,
  input wire logic [7:0] prog_load_data_i,
  // Control outputs.
  output ctrl_s ctrl_o,
  output logic stack_fault_o
);

  // ==========================================================================
  // Region decode.
  region_e region;
  logic [5:0] reg_off;
  logic [8:0] ram_idx;
  logic reg_wr;
  logic [7:0] reg_rdata;
  logic [7:0] reg_rdata_q;
  logic [7:0] ram_rdata;
  logic [7:0] prog_rdata;
  logic [7:0] tb_count_q;
  logic [7:0] tb_ctrl_q;
  logic [7:0] usb_dma_q;
  logic [7:0] usb_sel_q;
  logic [7:0] usb_stat_q;
  logic [7:0] usb_mask_q;
  logic [7:0] usb_daddr_q;
  logic [7:0] ep_q [0:5];
  region_e region_q;
  ctrl_s ctrl_q;

  assign reg_off = req_i.addr[5:0];
  assign ram_idx = 9'(req_i.addr - `AM_RAM_BASE);

  // Addresses are compared whole, so no alias of a region appears elsewhere.
  always_comb begin
    if (req_i.addr <= `AM_REG_PAGE_TOP) begin
      region = REGION_REG;
    end else if (req_i.addr >= `AM_RAM_BASE && req_i.addr <= `AM_RAM_TOP) begin
      region = REGION_RAM;
    end else if (req_i.addr >= `AM_PROG_BASE) begin
      region = REGION_PROG;
    end else begin
      region = REGION_HOLE;
    end
  end

  assign reg_wr = req_i.wr && (region == REGION_REG);

  // ==========================================================================
  // Memories.
  // The RAM reads every cycle; its data are used only when the request hit RAM.
  // Writes outside the RAM window never reach it, so the holes stay inert.
  ram_store ram_store_inst (
    .clk_i(clk_i),
    .we_i(req_i.wr && region == REGION_RAM),
    .addr_i(ram_idx),
    .wdata_i(req_i.wdata),
    .rdata_o(ram_rdata)
  );

  // Loading takes the address port over, so CPU fetches return the load address's byte while an image goes in.
  // The CPU has no write path here; program bytes change only through the load port.
  prog_store prog_store_inst (
    .clk_i(clk_i),
    .load_i(prog_load_i),
    .addr_i(prog_load_i ? prog_load_addr_i : req_i.addr[11:0]),
    .wdata_i(prog_load_data_i),
    .rdata_o(prog_rdata)
  );

  // ==========================================================================
  // Port, interrupt edge, misc, watchdog and USB control registers.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q.port_a_data <= `AM_RST_ZERO;
      ctrl_q.port_a_direction <= `AM_RST_ZERO;
      ctrl_q.port_b_data <= `AM_RST_ZERO;
      ctrl_q.port_b_direction <= `AM_RST_ZERO;
      ctrl_q.ext_int_edge_config <= `AM_RST_ZERO;
      ctrl_q.misc_control <= `AM_RST_ZERO;
      ctrl_q.watchdog_control <= `AM_RST_WDG;
      ctrl_q.usb_control <= `AM_RST_USB_CTRL;
    end else if (reg_wr) begin
      if (reg_off == `AM_PORT_A_DATA) begin
        ctrl_q.port_a_data <= req_i.wdata;
      end else if (reg_off == `AM_PORT_A_DIR) begin
        ctrl_q.port_a_direction <= req_i.wdata;
      end else if (reg_off == `AM_PORT_B_DATA) begin
        ctrl_q.port_b_data <= req_i.wdata;
      end else if (reg_off == `AM_PORT_B_DIR) begin
        ctrl_q.port_b_direction <= req_i.wdata;
      end else if (reg_off == `AM_EXT_INT_EDGE) begin
        ctrl_q.ext_int_edge_config <= req_i.wdata;
      end else if (reg_off == `AM_MISC_CONTROL) begin
        ctrl_q.misc_control <= req_i.wdata;
      end else if (reg_off == `AM_WDG_CONTROL) begin
        ctrl_q.watchdog_control <= req_i.wdata;
      end else if (reg_off == `AM_USB_CONTROL) begin
        ctrl_q.usb_control <= req_i.wdata;
      end
    end
  end

  // ==========================================================================
  // USB group registers; the packet id is read only and comes from outside.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      usb_dma_q <= `AM_RST_ZERO;
      usb_sel_q <= `AM_RST_ZERO;
      usb_stat_q <= `AM_RST_ZERO;
      usb_mask_q <= `AM_RST_ZERO;
      usb_daddr_q <= `AM_RST_ZERO;
    end else if (reg_wr) begin
      if (reg_off == `AM_USB_DMA_ADDR) begin
        usb_dma_q <= req_i.wdata;
      end else if (reg_off == `AM_USB_INT_DMA_SEL) begin
        usb_sel_q <= req_i.wdata;
      end else if (reg_off == `AM_USB_INT_STATUS) begin
        usb_stat_q <= req_i.wdata;
      end else if (reg_off == `AM_USB_INT_MASK) begin
        usb_mask_q <= req_i.wdata;
      end else if (reg_off == `AM_USB_DEV_ADDR) begin
        usb_daddr_q <= req_i.wdata;
      end
    end
  end

  // Endpoint A/B pairs fill the six bytes ending the USB group.
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_ep
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          ep_q[g] <= `AM_RST_ZERO;
        end else if (reg_wr && reg_off == 6'(`AM_USB_EP_BASE + g)) begin
          ep_q[g] <= req_i.wdata;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Timebase registers.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tb_count_q <= `AM_RST_ZERO;
      tb_ctrl_q <= `AM_RST_ZERO;
    end else if (reg_wr && reg_off == `AM_TB_COUNT) begin
      tb_count_q <= req_i.wdata;
    end else if (reg_wr && reg_off == `AM_TB_CTRL_STAT) begin
      tb_ctrl_q <= req_i.wdata;
    end
  end

  // ==========================================================================
  // Register read mux; holes fall through to zero.
  always_comb begin
    if (reg_off == `AM_PORT_A_DATA) begin
      reg_rdata = ctrl_q.port_a_data;
    end else if (reg_off == `AM_PORT_A_DIR) begin
      reg_rdata = ctrl_q.port_a_direction;
    end else if (reg_off == `AM_PORT_B_DATA) begin
      reg_rdata = ctrl_q.port_b_data;
    end else if (reg_off == `AM_PORT_B_DIR) begin
      reg_rdata = ctrl_q.port_b_direction;
    end else if (reg_off == `AM_EXT_INT_EDGE) begin
      reg_rdata = ctrl_q.ext_int_edge_config;
    end else if (reg_off == `AM_MISC_CONTROL) begin
      reg_rdata = ctrl_q.misc_control;
    end else if (reg_off == `AM_WDG_CONTROL) begin
      reg_rdata = ctrl_q.watchdog_control;
    end else if (reg_off == `AM_USB_PID) begin
      reg_rdata = usb_packet_id_i;
    end else if (reg_off == `AM_USB_DMA_ADDR) begin
      reg_rdata = usb_dma_q;
    end else if (reg_off == `AM_USB_INT_DMA_SEL) begin
      reg_rdata = usb_sel_q;
    end else if (reg_off == `AM_USB_INT_STATUS) begin
      reg_rdata = usb_stat_q;
    end else if (reg_off == `AM_USB_INT_MASK) begin
      reg_rdata = usb_mask_q;
    end else if (reg_off == `AM_USB_CONTROL) begin
      reg_rdata = ctrl_q.usb_control;
    end else if (reg_off == `AM_USB_DEV_ADDR) begin
      reg_rdata = usb_daddr_q;
    end else if (reg_off >= `AM_USB_EP_BASE && reg_off <= `AM_USB_EP_LAST) begin
      reg_rdata = ep_q[3'(reg_off - `AM_USB_EP_BASE)];
    end else if (reg_off == `AM_TB_COUNT) begin
      reg_rdata = tb_count_q;
    end else if (reg_off == `AM_TB_CTRL_STAT) begin
      reg_rdata = tb_ctrl_q;
    end else begin
      reg_rdata = `AM_RST_ZERO;
    end
  end

  // Register reads are captured so they line up with the memories' latency.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_q <= `AM_RST_ZERO;
      region_q <= REGION_HOLE;
    end else begin
      reg_rdata_q <= reg_rdata;
      region_q <= region;
    end
  end

  // ==========================================================================
  // Read data output, two cycles after the request.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= `AM_RST_ZERO;
      region_o <= REGION_HOLE;
    end else begin
      region_o <= region_q;
      case (region_q)
        REGION_REG: rdata_o <= reg_rdata_q;
        REGION_RAM: rdata_o <= ram_rdata;
        REGION_PROG: rdata_o <= prog_rdata;
        default: rdata_o <= `AM_RST_ZERO;
      endcase
    end
  end

  // Control bits leave through a flop so peripherals see clean levels.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o <= ctrl_q;
    end
  end

  // A push outside the stack window is flagged; sticky until reset.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stack_fault_o <= 1'b0;
    end else if (stack_push_i &&
                 (req_i.addr < `AM_STACK_BASE || req_i.addr > `AM_STACK_TOP)) begin
      stack_fault_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks.
  chk_wdg_reset_val: assert property (@(posedge clk_i)
    !reset_n_i |=> ctrl_q.watchdog_control == 8'h7f)
    else $error("watchdog control reset value wrong");

  chk_port_a_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == 16'h0000 |=> ctrl_q.port_a_data == $past(req_i.wdata))
    else $error("port a data write lost");

  chk_port_b_dir: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == 16'h0003 |=> ctrl_q.port_b_direction == $past(req_i.wdata))
    else $error("port b direction write lost");

  chk_hole_reads_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.addr >= 16'h0004 && req_i.addr <= 16'h0007 ##2 1 |-> rdata_o == 8'h00)
    else $error("reserved address read not zero");

  chk_ram_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.addr >= 16'h0040 && req_i.addr <= 16'h01bf |-> ##2 region_o == REGION_RAM)
    else $error("ram range decode wrong");

  chk_prog_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.addr >= 16'hf000 |-> ##2 region_o == REGION_PROG)
    else $error("program sector decode wrong");

  chk_misc_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == 16'h0009 |=> ##1 ctrl_o.misc_control == $past(req_i.wdata, 2))
    else $error("misc control write did not reach output");

  chk_pid_read_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.addr == 16'h0025 |-> ##2 rdata_o == $past(usb_packet_id_i, 2))
    else $error("packet id read wrong");

  // Writes into the 0004h to 0007h hole must leave every register in ctrl_q untouched.
  chk_hole_write_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr >= 16'h0004 && req_i.addr <= 16'h0007 |=> $stable(ctrl_q))
    else $error("write to reserved hole changed a register");

  // Nothing between the RAM top and the program sector may claim a region.
  chk_gap_is_hole: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.addr > 16'h01bf && req_i.addr < 16'hf000 |-> ##2 region_o == REGION_HOLE)
    else $error("address gap decoded as a region");

  // The last endpoint slot closes the USB group.
  chk_ep_last_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == 16'h0031 |=> ep_q[5] == $past(req_i.wdata))
    else $error("endpoint register write lost");

  chk_tb_count_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == 16'h0036 |=> tb_count_q == $past(req_i.wdata))
    else $error("timebase count write lost");

  // A push outside the stack window must raise the fault at the next edge.
  chk_stack_fault_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stack_push_i && (req_i.addr < 16'h0100 || req_i.addr > 16'h017f) |=> stack_fault_o)
    else $error("stack overflow push not flagged");

  // The fault is sticky; only reset may clear it.
  chk_stack_fault_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stack_fault_o |=> stack_fault_o)
    else $error("stack fault cleared without reset");

endmodule

`default_nettype wire

/* File: inc/addr_map_cfg.svh */
`ifndef ADDR_MAP_CFG_SVH
`define ADDR_MAP_CFG_SVH

// ==========================================================================
// Address space layout.
`define AM_REG_PAGE_TOP 16'h003f
`define AM_RAM_BASE 16'h0040
`define AM_RAM_BYTES 384
`define AM_RAM_TOP 16'h01bf
`define AM_STACK_BASE 16'h0100
`define AM_STACK_TOP 16'h017f
`define AM_PROG_BASE 16'hf000
`define AM_VECT_BASE 16'hffe0

// ==========================================================================
// Register offsets within the register page.
`define AM_PORT_A_DATA 6'h00
`define AM_PORT_A_DIR 6'h01
`define AM_PORT_B_DATA 6'h02
`define AM_PORT_B_DIR 6'h03
`define AM_EXT_INT_EDGE 6'h08
`define AM_MISC_CONTROL 6'h09
`define AM_WDG_CONTROL 6'h0d
`define AM_USB_PID 6'h25
`define AM_USB_DMA_ADDR 6'h26
`define AM_USB_INT_DMA_SEL 6'h27
`define AM_USB_INT_STATUS 6'h28
`define AM_USB_INT_MASK 6'h29
`define AM_USB_CONTROL 6'h2a
`define AM_USB_DEV_ADDR 6'h2b
`define AM_USB_EP_BASE 6'h2c
`define AM_USB_EP_LAST 6'h31
`define AM_TB_COUNT 6'h36
`define AM_TB_CTRL_STAT 6'h37

// ==========================================================================
// Reset values.
`define AM_RST_ZERO 8'h00
`define AM_RST_WDG 8'h7f
`define AM_RST_USB_CTRL 8'h06

`endif

/* File: inc/addr_map_pkg.sv */
package addr_map_pkg;

  // Region that a CPU address falls into.
  typedef enum logic [2:0] {
    REGION_REG,
    REGION_RAM,
    REGION_PROG,
    REGION_HOLE
  } region_e;

  // One CPU bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } cpu_req_s;

  // Register file outputs steering the peripherals.
  typedef struct packed {
    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_data;
    logic [7:0] port_b_direction;
    logic [7:0] ext_int_edge_config;
    logic [7:0] misc_control;
    logic [7:0] watchdog_control;
    logic [7:0] usb_control;
  } ctrl_s;

endpackage

/* File: design/ram_store.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Byte-wide single-port RAM with registered read data.
module ram_store
  import addr_map_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Access port.
  input wire logic we_i,
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [0:383];

  // Write and read share the port; read returns the old contents.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

`default_nettype wire

/* File: design/prog_store.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Program memory image, 4 Kbytes, read only from the CPU side.
module prog_store
  import addr_map_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Load port used by the programming path.
  input wire logic load_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [0:4095];

  // Contents come only from the load port; no image file is read.
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

`default_nettype wire

/* File: sim/cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// CPU core stand-in issuing one byte access at a time off the falling edge.
module cpu_model
  import addr_map_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Bus towards the decoder.
  output var cpu_req_s req_o,
  output var logic push_o,
  input wire logic [7:0] rdata_i,
  input wire region_e region_i
);

  // The bus starts idle so nothing is taken during reset.
  initial begin
    req_o = '0;
    push_o = 1'b0;
  end

  // Single-cycle write strobe; the address stays put until the next access.
  task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    req_o = '{addr: addr, wdata: data, rd: 1'b0, wr: 1'b1};
    @(negedge clk_i);
    req_o.wr = 1'b0;
  endtask

  // The answer lands two edges after the address edge, so it is read at the third fall.
  task automatic read_byte(input logic [15:0] addr, output logic [7:0] data,
                           output region_e reg_got);
    @(negedge clk_i);
    req_o = '{addr: addr, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
    repeat (3) @(negedge clk_i);
    data = rdata_i;
    reg_got = region_i;
    req_o.rd = 1'b0;
  endtask

  // A push is a stack write flagged for one cycle.
  task automatic push_byte(input logic [15:0] addr);
    @(negedge clk_i);
    req_o = '{addr: addr, wdata: 8'h3c, rd: 1'b0, wr: 1'b1};
    push_o = 1'b1;
    @(negedge clk_i);
    push_o = 1'b0;
    req_o.wr = 1'b0;
  endtask

endmodule

`default_nettype wire

/* File: sim/test_addr_map_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Self-checking bench for the address map decoder.
module test_addr_map_decoder
  import addr_map_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i;
  cpu_req_s req;
  logic push;
  logic [7:0] rdata;
  region_e region;
  ctrl_s ctrl;
  logic stack_fault;
  logic prog_load;
  logic [11:0] prog_addr;
  logic [7:0] prog_data;
  logic [7:0] usb_pid;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [15:0] regs [21] = '{16'h00, 16'h01, 16'h02, 16'h03, 16'h08, 16'h09, 16'h0d,
    16'h26, 16'h27, 16'h28, 16'h29, 16'h2a, 16'h2b, 16'h2c, 16'h2d, 16'h2e, 16'h2f,
    16'h30, 16'h31, 16'h36, 16'h37};

  // ==========================================================================
  // Clock, design and CPU stand-in.
  always #5 clk_i = ~clk_i;

  addr_map_decoder addr_map_decoder_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .rdata_o(rdata),
    .region_o(region), .usb_packet_id_i(usb_pid), .stack_push_i(push),
    .prog_load_i(prog_load), .prog_load_addr_i(prog_addr),
    .prog_load_data_i(prog_data), .ctrl_o(ctrl), .stack_fault_o(stack_fault));

  cpu_model cpu_model_inst (
    .clk_i(clk_i), .req_o(req), .push_o(push), .rdata_i(rdata), .region_i(region));

  // ==========================================================================
  // Comparison and access helpers.
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_region(input region_e got, input region_e exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: region %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic read_chk(input logic [15:0] a, input logic [7:0] exp, input region_e er);
    logic [7:0] d;
    region_e r;
    cpu_model_inst.read_byte(a, d, r);
    cmp_byte(d, exp);
    cmp_region(r, er);
  endtask

  // Each register gets its own pattern so a decode alias shows up.
  function automatic logic [7:0] wval(input logic [15:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction

  // ==========================================================================
  // Scenarios.
  task automatic check_reset();
    foreach (regs[i]) begin
      read_chk(regs[i], regs[i] == 16'h0d ? 8'h7f : regs[i] == 16'h2a ? 8'h06 : 8'h00,
               REGION_REG);
    end
    cmp_byte(ctrl.watchdog_control, 8'h7f);
    cmp_byte(ctrl.usb_control, 8'h06);
    cmp_byte({7'h00, stack_fault}, 8'h00);
  endtask

  task automatic check_registers();
    foreach (regs[i]) cpu_model_inst.write_byte(regs[i], wval(regs[i]));
    foreach (regs[i]) begin
      read_chk(regs[i], wval(regs[i]), REGION_REG);
    end
    // The packet id follows its input and ignores CPU writes.
    cpu_model_inst.write_byte(16'h25, 8'hff);
    read_chk(16'h25, usb_pid, REGION_REG);
  endtask

  task automatic check_reserved();
    for (int a = 4; a <= 16'h24; a++) begin
      if (a inside {[4:7], [10:12], [14:36]}) begin
        cpu_model_inst.write_byte(a[15:0], 8'hff);
        read_chk(a[15:0], 8'h00, REGION_REG);
      end
    end
    cmp_byte(ctrl.port_a_data, wval(16'h00));
    cmp_byte(ctrl.port_b_direction, wval(16'h03));
    cmp_byte(ctrl.misc_control, wval(16'h09));
    cmp_byte(ctrl.watchdog_control, wval(16'h0d));
    cmp_byte(ctrl.port_a_direction, wval(16'h01));
    cmp_byte(ctrl.port_b_data, wval(16'h02));
    cmp_byte(ctrl.ext_int_edge_config, wval(16'h08));
    cmp_byte(ctrl.usb_control, wval(16'h2a));
  endtask

  task automatic check_memories();
    logic [15:0] ram [4] = '{16'h0040, 16'h0100, 16'h017f, 16'h01bf};
    foreach (ram[i]) cpu_model_inst.write_byte(ram[i], ram[i][7:0] ^ 8'h5c);
    foreach (ram[i]) read_chk(ram[i], ram[i][7:0] ^ 8'h5c, REGION_RAM);
    read_chk(16'h003f, 8'h00, REGION_REG);
    cpu_model_inst.write_byte(16'h01c0, 8'hff);
    read_chk(16'h01c0, 8'h00, REGION_HOLE);
    read_chk(16'hefff, 8'h00, REGION_HOLE);
    // Load the image through the load port, then try a CPU write over the top byte.
    @(negedge clk_i);
    prog_load = 1'b1;
    prog_addr = 12'h000;
    prog_data = 8'h11;
    @(negedge clk_i);
    prog_addr = 12'hfff;
    prog_data = 8'hee;
    @(negedge clk_i);
    prog_load = 1'b0;
    cpu_model_inst.write_byte(16'hffff, 8'h00);
    read_chk(16'hf000, 8'h11, REGION_PROG);
    read_chk(16'hffff, 8'hee, REGION_PROG);
  endtask

  task automatic check_stack();
    cpu_model_inst.push_byte(16'h0100);
    cpu_model_inst.push_byte(16'h017f);
    repeat (2) @(negedge clk_i);
    cmp_byte({7'h00, stack_fault}, 8'h00);
    cpu_model_inst.push_byte(16'h0180);
    repeat (2) @(negedge clk_i);
    cmp_byte({7'h00, stack_fault}, 8'h01);
    cpu_model_inst.push_byte(16'h0100);
    repeat (2) @(negedge clk_i);
    cmp_byte({7'h00, stack_fault}, 8'h01);
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence.
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand accesses, so this span is generous.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    reset_n_i = 1'b0;
    prog_load = 1'b0;
    prog_addr = 12'h000;
    prog_data = 8'h00;
    usb_pid = 8'h3c;
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    check_reset();
    check_registers();
    check_reserved();
    check_memories();
    check_stack();
    end_sim();
  end

endmodule

`default_nettype wire
